// file: shared/qgfc_pkg.sv
// qgfc_pkg: constants, field positions and timing counts for the quad gate fault control block
// Notes on behaviour
// - serial bits are active high except the not-write flag in the fault byte.
// - a control byte with D5 clear is discarded whole.
// - address bits D7:D6 select channel 1 to 4 in both bytes.
// - control bits D0-D4 act on the addressed channel; fault bits D0-D2 report it.
// - gate on when discrete input high or stored gate bit set.
// - ground-short monitoring starts after gate on plus selected turn-on blank time.
// - ground-short trip latches fault, discharges gate and asserts fault line.
// - ground-short fault holds until cleared; other channels keep running.
// - every turn-off blanks battery-short detection; afterwards a trip latches it.
// - battery-short fault disables gate without pull-down until cleared or masked.
// - turn-off blanks open-load detection; afterwards a trip latches and disables.
// - after blanking, a fault registers only if persisting beyond the filter time.
// - thermal warning sets fault bit D3 and the fault line, nothing else.
// - charge pump undervoltage sets bit D4, fault line, disables all gates.
// - fault byte bit D5 is always shifted out as zero.
// - fault byte D0 ground short, D1 battery short, D2 open load.
// - master reset pulse clears latched faults and both serial registers.
// - master reset held low beyond sleep entry time enters sleep.
// - enable pin low actively pulls every gate low outside sleep.
// - fault line is an active-low open-drain output.
// - control byte with D3 set clears addressed channel's latched load faults.
// - mask bit D4 ignores battery-short and open-load faults, never ground shorts.
// - turn-on blank select bits default to 00.
// - shift register moves into control register when chip select releases.
package qgfc_pkg;
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int CTL_GATE   = 0;
  localparam int CTL_BLK_LO = 1;
  localparam int CTL_BLK_HI = 2;
  localparam int CTL_CLEAR  = 3;
  localparam int CTL_MASK   = 4;
  localparam int CTL_READ   = 5;
  localparam int ADDR_LO    = 6;
  localparam int ADDR_HI    = 7;
  localparam int FLT_STG    = 0;
  localparam int FLT_STB    = 1;
  localparam int FLT_OL     = 2;
  localparam int FLT_THERM  = 3;
  localparam int FLT_UV     = 4;
  localparam int FLT_NWR    = 5;
  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [4:0] CHAN_CTL_RESET = 5'h00;
  localparam logic [7:0] FAULT_RESET    = 8'h00;
  localparam logic [1:0] BLANK_SEL_RESET = 2'h0;
  // ----------------------------------------
  // timing, in us at a 10 MHz system clock
  // ----------------------------------------
  localparam int CLK_MHZ = 10;
  localparam int TON00_US = 6;
  localparam int TON01_US = 12;
  localparam int TON10_US = 24;
  localparam int TON11_US = 48;
  localparam int TURN_OFF_BLANK_TIME_US = 12;
  localparam int TFF_US = 3;
  localparam int SLEEP_ENTRY_TIME_US = 100;
  localparam int TON00_CYC = TON00_US * CLK_MHZ;
  localparam int TON01_CYC = TON01_US * CLK_MHZ;
  localparam int TON10_CYC = TON10_US * CLK_MHZ;
  localparam int TON11_CYC = TON11_US * CLK_MHZ;
  localparam int TURN_OFF_BLANK_TIME_CYC = TURN_OFF_BLANK_TIME_US * CLK_MHZ;
  localparam int TFF_CYC = TFF_US * CLK_MHZ;
  localparam int SLEEP_ENTRY_TIME_CYC = SLEEP_ENTRY_TIME_US * CLK_MHZ;
  localparam int TMR_W = 10;
endpackage : qgfc_pkg

// file: rtl/qgfc_channel.sv
// qgfc_channel: one channel's gate control, blanking, filtering and fault latches
`timescale 1ns/1ps
`default_nettype none
module qgfc_channel
  import qgfc_pkg::*;
(
  // clock and reset
  input  wire logic       clk_sys_in,
  input  wire logic       rst_n_in,
  // control
  input  wire logic       in_pin_in,
  input  wire logic [4:0] ctl_in,
  input  wire logic       clear_in,
  input  wire logic       enable_in,
  input  wire logic       uv_in,
  input  wire logic       flt_clr_in,
  // comparators, already synchronised
  input  wire logic       vds_trip_in,
  input  wire logic       stb_trip_in,
  input  wire logic       ol_trip_in,
  // results
  output logic            gate_on_out,
  output logic            gate_pull_out,
  output logic [2:0]      fault_out
);
  // ----------------------------------------
  // command and gate decode
  // ----------------------------------------
  logic [TMR_W-1:0] blank_cnt;
  logic [TMR_W-1:0] stg_cnt;
  logic [TMR_W-1:0] stb_cnt;
  logic [TMR_W-1:0] ol_cnt;
  logic             stg;
  logic             stb;
  logic             ol;
  logic             gate_q;
  logic [TMR_W-1:0] ton_cyc;
  wire  logic       mask     = ctl_in[CTL_MASK];
  wire  logic       want_on  = in_pin_in | ctl_in[CTL_GATE];
  wire  logic       off_flt  = ~mask & (stb | ol);
  wire  logic       disabled = off_flt | uv_in;
  wire  logic       gate_on  = enable_in & want_on & ~stg & ~disabled;
  wire  logic       turn_off = gate_q & ~gate_on;
  wire  logic       blanked  = blank_cnt != '0;
  wire  logic       stg_mon  = gate_on & ~blanked & vds_trip_in;
  wire  logic       off_mon  = ~gate_q & ~blanked & ~mask;
  wire  logic       clr      = clear_in | flt_clr_in;
  always_comb
  begin
    case (ctl_in[CTL_BLK_HI:CTL_BLK_LO])
      2'h0:    ton_cyc = TMR_W'(TON00_CYC);
      2'h1:    ton_cyc = TMR_W'(TON01_CYC);
      2'h2:    ton_cyc = TMR_W'(TON10_CYC);
      default: ton_cyc = TMR_W'(TON11_CYC);
    endcase
  end
  assign gate_on_out   = gate_on;
  // stb/ol disable leaves the gate floating, every other off pulls down
  assign gate_pull_out = ~gate_on & ~(off_flt & enable_in & ~uv_in & ~stg);
  assign fault_out     = {ol & ~mask, stb & ~mask, stg};
  // ----------------------------------------
  // blanking timer, restarted on each edge of the gate
  // ----------------------------------------
  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
    begin
      gate_q    <= 1'b0;
      blank_cnt <= '0;
    end
    else
    begin
      gate_q <= gate_on;
      if (gate_on & ~gate_q)
        blank_cnt <= ton_cyc;
      else if (turn_off)
        blank_cnt <= TMR_W'(TURN_OFF_BLANK_TIME_CYC);
      else if (blanked)
        blank_cnt <= blank_cnt - 1'b1;
    end
  end
  // ----------------------------------------
  // filters and latches; a set beats a clear
  // ----------------------------------------
  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
    begin
      stg_cnt <= '0;
      stb_cnt <= '0;
      ol_cnt  <= '0;
      stg     <= 1'b0;
      stb     <= 1'b0;
      ol      <= 1'b0;
    end
    else
    begin
      stg_cnt <= stg_mon ? stg_cnt + 1'b1 : '0;
      stb_cnt <= (off_mon & stb_trip_in) ? stb_cnt + 1'b1 : '0;
      ol_cnt  <= (off_mon & ol_trip_in) ? ol_cnt + 1'b1 : '0;
      if (stg_mon && stg_cnt >= TMR_W'(TFF_CYC))
        stg <= 1'b1;
      else if (clr)
        stg <= 1'b0;
      if (off_mon && stb_trip_in && stb_cnt >= TMR_W'(TFF_CYC))
        stb <= 1'b1;
      else if (clr)
        stb <= 1'b0;
      if (off_mon && ol_trip_in && ol_cnt >= TMR_W'(TFF_CYC))
        ol <= 1'b1;
      else if (clr)
        ol <= 1'b0;
    end
  end
endmodule : qgfc_channel
`default_nettype wire

// file: rtl/qgfc_top.sv
// qgfc_top: serial control and fault report logic of a four-channel gate driver
`timescale 1ns/1ps
`default_nettype none
module qgfc_top
  import qgfc_pkg::*;
(
  // clock and reset
  input  wire logic       clk_sys_in,
  input  wire logic       rst_n_in,
  // serial link, own clock domain
  input  wire logic       sclk_in,
  input  wire logic       chip_select_n_in,
  input  wire logic       sdi_in,
  output logic            sdo_out,
  output logic            sdo_oe_n_out,
  // device pins
  input  wire logic       master_reset_sleep_n_in,
  input  wire logic       output_enable_pin_in,
  input  wire logic [3:0] discrete_channel_input_in,
  // comparators and system indications
  input  wire logic [3:0] drain_sense_pin_in,
  input  wire logic [3:0] source_sense_pin_in,
  input  wire logic [3:0] open_load_trip_in,
  input  wire logic       thermal_warning_in,
  input  wire logic       undervoltage_lockout_in,
  // gate drive and status
  output logic [3:0]      gate_drive_output_out,
  output logic [3:0]      gate_pull_down_out,
  output logic            fault_alert_n_out,
  output logic            fault_alert_n_oe_n_out,
  output logic            sleep_out
);
  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  localparam int NSYNC = 20;
  logic [NSYNC-1:0] sync1;
  logic [NSYNC-1:0] sync2;
  wire  logic [NSYNC-1:0] raw = {master_reset_sleep_n_in, output_enable_pin_in,
                                 thermal_warning_in, undervoltage_lockout_in,
                                 discrete_channel_input_in, drain_sense_pin_in,
                                 source_sense_pin_in, open_load_trip_in};
  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
    begin
      sync1 <= '0;
      sync2 <= '0;
    end
    else
    begin
      sync1 <= raw;
      sync2 <= sync1;
    end
  end
  wire logic       mrst_n  = sync2[19];
  wire logic       output_enable_pin     = sync2[18];
  wire logic       therm   = sync2[17];
  wire logic       uv      = sync2[16];
  wire logic [3:0] in_pins = sync2[15:12];
  wire logic [3:0] vds     = sync2[11:8];
  wire logic [3:0] stbc    = sync2[7:4];
  wire logic [3:0] olc     = sync2[3:0];
  // ----------------------------------------
  // master reset and sleep
  // ----------------------------------------
  logic [TMR_W-1:0] sleep_cnt;
  logic             asleep;
  wire  logic       soft_clr = ~mrst_n;
  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
    begin
      sleep_cnt <= '0;
      asleep    <= 1'b0;
    end
    else if (mrst_n)
    begin
      sleep_cnt <= '0;
      asleep    <= 1'b0;
    end
    else if (sleep_cnt >= TMR_W'(SLEEP_ENTRY_TIME_CYC))
      asleep <= 1'b1;
    else
      sleep_cnt <= sleep_cnt + 1'b1;
  end
  assign sleep_out = asleep;
  // ----------------------------------------
  // link domain: shift register on the serial clock
  // ----------------------------------------
  logic [7:0] shift;
  logic [7:0] fb_hold;
  logic [3:0] bitcnt;
  logic [7:0] rx_word;
  logic       word_ok;
  logic       sdo_q;
  // fault byte is reloaded every system clock, also while chip select is low; it is sampled here at the first serial clock
  always_ff @(posedge sclk_in or posedge chip_select_n_in)
  begin
    if (chip_select_n_in)
    begin
      bitcnt <= 4'h0;
      shift  <= 8'h00;
    end
    else
    begin
      if (bitcnt == 4'h0)
        shift <= {fb_hold[6:0], sdi_in};
      else
        shift <= {shift[6:0], sdi_in};
      bitcnt <= (bitcnt == 4'h8) ? 4'h1 : bitcnt + 4'h1;
    end
  end
  always_ff @(negedge sclk_in or posedge chip_select_n_in)
  begin
    if (chip_select_n_in)
      sdo_q <= 1'b0;
    else
      sdo_q <= (bitcnt == 4'h0) ? fb_hold[6] : shift[7];
  end
  assign sdo_out      = (bitcnt == 4'h0) ? fb_hold[7] : sdo_q;
  assign sdo_oe_n_out = chip_select_n_in;
  // end of frame: word is taken on chip select release, ragged frames dropped
  always_ff @(posedge chip_select_n_in)
  begin
    word_ok <= (bitcnt == 4'h8);
    if (bitcnt == 4'h8)
      rx_word <= shift;
  end
  // ----------------------------------------
  // crossing into the system domain
  // ----------------------------------------
  // chip select is synchronised as a level; word and its flag stay quiet
  // through the inactive gap, so they are read only after the synced rise
  logic [2:0] cs_s;
  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
      cs_s <= 3'h7;
    else
      cs_s <= {cs_s[1:0], chip_select_n_in};
  end
  wire logic frame_end = cs_s[1] & ~cs_s[2];
  wire logic rx_evt    = frame_end & word_ok;
  // ----------------------------------------
  // control registers
  // ----------------------------------------
  logic [4:0] chan_ctl [4];
  wire  logic       cmd_ok   = rx_evt & rx_word[CTL_READ];
  wire  logic [1:0] cmd_chan = rx_word[ADDR_HI:ADDR_LO];
  genvar g;
  logic [3:0] clr_pulse;
  logic [2:0] chan_flt [4];
  logic [3:0] g_on;
  logic [3:0] g_pd;
  generate
    for (g = 0; g < 4; g++)
    begin : g_ch
      wire logic hit = cmd_ok & (cmd_chan == 2'(g));
      always_ff @(posedge clk_sys_in)
      begin
        if (!rst_n_in || soft_clr)
          chan_ctl[g] <= CHAN_CTL_RESET;
        else if (hit)
          chan_ctl[g] <= {rx_word[CTL_MASK], 1'b0, rx_word[CTL_BLK_HI:CTL_GATE]};
      end
      assign clr_pulse[g] = hit & rx_word[CTL_CLEAR];
      qgfc_channel u_ch
      (
        .clk_sys_in    (clk_sys_in),
        .rst_n_in      (rst_n_in),
        .in_pin_in     (in_pins[g]),
        .ctl_in        (chan_ctl[g]),
        .clear_in      (clr_pulse[g]),
        .enable_in     (output_enable_pin & ~asleep),
        .uv_in         (uv),
        .flt_clr_in    (soft_clr),
        .vds_trip_in   (vds[g]),
        .stb_trip_in   (stbc[g]),
        .ol_trip_in    (olc[g]),
        .gate_on_out   (g_on[g]),
        .gate_pull_out (g_pd[g]),
        .fault_out     (chan_flt[g])
      );
    end
  endgenerate
  assign gate_drive_output_out = g_on;
  assign gate_pull_down_out    = g_pd & {4{~asleep}};
  // ----------------------------------------
  // fault report: system flags stick until read, channels polled upward
  // ----------------------------------------
  logic       therm_f;
  logic       uv_f;
  logic [1:0] poll;
  logic [1:0] pick;
  logic       any_load;
  always_comb
  begin
    pick     = poll;
    any_load = 1'b0;
    for (int k = 3; k >= 0; k--)
    begin
      if (chan_flt[(int'(poll) + k) % 4] != 3'h0)
      begin
        pick     = 2'((int'(poll) + k) % 4);
        any_load = 1'b1;
      end
    end
  end
  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in || soft_clr)
    begin
      therm_f <= 1'b0;
      uv_f    <= 1'b0;
      poll    <= 2'h0;
      fb_hold <= FAULT_RESET;
    end
    else
    begin
      therm_f <= therm | (therm_f & ~frame_end);
      uv_f    <= uv | (uv_f & ~frame_end);
      if (frame_end)
        poll <= pick + 2'h1;
      fb_hold <= {any_load ? pick : 2'h0, 1'b0, uv_f, therm_f,
                  any_load ? chan_flt[pick] : 3'h0};
    end
  end
  // ----------------------------------------
  // open-drain fault line, enable low means driving low
  // ----------------------------------------
  wire logic any_fault = therm | uv | therm_f | uv_f | any_load;
  assign fault_alert_n_out      = 1'b0;
  assign fault_alert_n_oe_n_out = ~any_fault;
endmodule : qgfc_top
`default_nettype wire

// file: testbench/qgfc_checker.sv
// qgfc_checker: port-level assertions for the gate fault control block
`timescale 1ns/1ps
`default_nettype none
module qgfc_checker
  import qgfc_pkg::*;
(
  // clock and reset
  input wire logic       clk_sys_in,
  input wire logic       rst_n_in,
  // device pins
  input wire logic       master_reset_sleep_n_in,
  input wire logic       output_enable_pin_in,
  input wire logic [3:0] discrete_channel_input_in,
  input wire logic [3:0] drain_sense_pin_in,
  input wire logic       undervoltage_lockout_in,
  // outputs
  input wire logic [3:0] gate_drive_output_out,
  input wire logic [3:0] gate_pull_down_out,
  input wire logic       fault_alert_n_out,
  input wire logic       fault_alert_n_oe_n_out,
  input wire logic       sleep_out
);
  // ----------------------------------------
  // helper counters
  // ----------------------------------------
  logic [11:0] low_cnt;
  logic [9:0]  stg_cnt;
  wire         stg_hold = gate_drive_output_out[0] && drain_sense_pin_in[0];
  always_ff @(posedge clk_sys_in)
  begin
    low_cnt <= (!rst_n_in || master_reset_sleep_n_in) ? 12'h000 : low_cnt + 12'h001;
    stg_cnt <= (!rst_n_in || !stg_hold) ? 10'h000 : stg_cnt + 10'h001;
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  property p_enable_low;
    (!output_enable_pin_in)[*4] |-> gate_drive_output_out == 4'h0
      && (sleep_out || gate_pull_down_out == 4'hF);
  endproperty
  a_enable_low: assert property (p_enable_low)
    else $error("gates not pulled low while disabled");
  property p_uv; undervoltage_lockout_in[*4] |-> gate_drive_output_out == 4'h0
    && !fault_alert_n_oe_n_out; endproperty
  a_uv: assert property (p_uv)
    else $error("undervoltage did not stop gates");
  property p_fault_drive; fault_alert_n_out == 1'b0; endproperty
  a_fault_drive: assert property (p_fault_drive)
    else $error("fault line drives high");
  property p_exclusive; (gate_drive_output_out & gate_pull_down_out) == 4'h0; endproperty
  a_exclusive: assert property (p_exclusive)
    else $error("gate driven and pulled at once");
  // a floating gate outside sleep can only come from a latched off-state fault
  property p_float_fault; !sleep_out && (gate_drive_output_out | gate_pull_down_out) != 4'hF
    |-> ##[0:2] !fault_alert_n_oe_n_out; endproperty
  a_float_fault: assert property (p_float_fault)
    else $error("gate floating without fault line");
  property p_follow_pin;
    (discrete_channel_input_in[0] && output_enable_pin_in && !undervoltage_lockout_in
      && master_reset_sleep_n_in && !sleep_out)[*4]
      ##0 (fault_alert_n_oe_n_out && $past(fault_alert_n_oe_n_out)) |-> gate_drive_output_out[0];
  endproperty
  a_follow_pin: assert property (p_follow_pin)
    else $error("gate not following its input");
  // longest blank plus filter plus synchroniser delay
  property p_stg_bound; stg_cnt <= 10'd530; endproperty
  a_stg_bound: assert property (p_stg_bound)
    else $error("ground short never discharged gate");
  property p_sleep_late; $rose(sleep_out) |-> low_cnt > 12'd1000; endproperty
  a_sleep_late: assert property (p_sleep_late)
    else $error("sleep entered too early");
  property p_sleep_entry; low_cnt == 12'd1010 |-> sleep_out; endproperty
  a_sleep_entry: assert property (p_sleep_entry)
    else $error("sleep not entered");
endmodule : qgfc_checker
bind qgfc_top qgfc_checker qgfc_checker_inst (.*);
`default_nettype wire

// file: testbench/qgfc_spi_master.sv
// qgfc_spi_master: serial controller model on the far side of the link
`timescale 1ns/1ps
`default_nettype none
module qgfc_spi_master
(
  // link pins
  output logic       sclk_out,
  output logic       cs_n_out,
  output logic       sdi_out,
  input  wire logic  sdo_in,
  input  wire logic  sdo_oe_n_in,
  // received byte
  output logic [7:0] rx_out
);
  event done_ev;
  initial
  begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    sdi_out  = 1'b1;
    rx_out   = 8'h00;
  end
  // clock stands still outside frames; lead time picks prompt or slow
  task automatic frame(input logic [7:0] tx, input int nbits, input int lead_ns);
    cs_n_out = 1'b0;
    #(lead_ns);
    for (int i = 0; i < nbits; i++)
    begin
      sdi_out = tx[7 - i];
      #6;
      sclk_out = 1'b1;
      rx_out = {rx_out[6:0], sdo_oe_n_in ? 1'bx : sdo_in};
      #6;
      sclk_out = 1'b0;
    end
    #(lead_ns);
    cs_n_out = 1'b1;
    sdi_out = ~sdi_out;
    if (nbits == 8) -> done_ev;
  endtask : frame
endmodule : qgfc_spi_master
`default_nettype wire

// file: testbench/tb.sv
// tb: self-checking bench for the quad gate fault control block
`timescale 1ns/1ps
`default_nettype none
module tb
  import qgfc_pkg::*;
;
  logic        clk_sys_in = 1'b0;
  logic        rst_n_in = 1'b0;
  logic        mrst_n = 1'b1, en = 1'b1, therm = 1'b0, uv = 1'b0;
  logic [3:0]  din = 4'h0, drn = 4'h0, src = 4'h0, olt = 4'h0, gate, pull, g;
  logic        sclk, cs_n, sdi, sdo, sdo_oe_n, flt, flt_oe_n, slp;
  logic [7:0]  rx;
  logic [8:0]  note;
  logic [8:0]  fq[$];
  logic [9:0]  sq[$];
  logic [31:0] seed = 32'd92001;
  int          error_cnt = 0, checks_done = 0, cyc = 0;
  event        snap_ev;
  qgfc_top qgfc_top_inst (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
    .sclk_in(sclk), .chip_select_n_in(cs_n), .sdi_in(sdi), .sdo_out(sdo),
    .sdo_oe_n_out(sdo_oe_n), .master_reset_sleep_n_in(mrst_n), .output_enable_pin_in(en),
    .discrete_channel_input_in(din), .drain_sense_pin_in(drn), .source_sense_pin_in(src),
    .open_load_trip_in(olt), .thermal_warning_in(therm), .undervoltage_lockout_in(uv),
    .gate_drive_output_out(gate), .gate_pull_down_out(pull), .fault_alert_n_out(flt),
    .fault_alert_n_oe_n_out(flt_oe_n), .sleep_out(slp));
  qgfc_spi_master qgfc_spi_master_inst (.sclk_out(sclk), .cs_n_out(cs_n), .sdi_out(sdi),
    .sdo_in(sdo), .sdo_oe_n_in(sdo_oe_n), .rx_out(rx));
  // ----------------------------------------
  // clock, timeout, helpers
  // ----------------------------------------
  initial
  begin
    forever #50 clk_sys_in = ~clk_sys_in;
  end
  always @(posedge clk_sys_in)
  begin
    cyc <= cyc + 1;
    if (cyc == 8000)
    begin
      error_cnt++;
      print_verdict();
    end
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic tally(input logic ok, input logic [9:0] e, input logic [9:0] v);
    checks_done++;
    if (!ok)
    begin
      error_cnt++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, v);
    end
  endtask : tally
  task automatic chk_fault(input logic [7:0] e, input logic [7:0] v);
    tally(v === e, {2'b00, e}, {2'b00, v});
  endtask : chk_fault
  task automatic chk_snap(input logic [9:0] e, input logic [9:0] v);
    tally(v === e, e, v);
  endtask : chk_snap
  always @(qgfc_spi_master_inst.done_ev)
  begin
    note = fq.pop_front();
    if (note[8]) chk_fault(note[7:0], rx);
  end
  always @(snap_ev) chk_snap(sq.pop_front(), {flt_oe_n, slp, pull, gate});
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask : wait_clk
  // the gap after each frame covers the crossing and the fault byte reload
  task automatic xfer(input logic [7:0] tx, input int n, input logic c, input logic [7:0] e);
    if (n == 8) fq.push_back({c, e});
    qgfc_spi_master_inst.frame(tx, n, (rnd() & 32'h1) ? 400 : 20);
    wait_clk(25);
  endtask : xfer
  // the byte is taken at the first clock of a frame and sticky flags clear at its end, so read twice
  task automatic rd(input logic [7:0] e);
    xfer(8'(rnd()) & 8'hDF, 8, 1'b0, 8'h00);
    xfer(8'(rnd()) & 8'hDF, 8, 1'b1, e);
  endtask : rd
  task automatic snap(input logic [9:0] e);
    sq.push_back(e);
    -> snap_ev;
  endtask : snap
  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : print_verdict
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial
  begin
    wait_clk(3);
    rst_n_in = 1'b1;
    wait_clk(20);
    snap(10'h2F0);
    for (int c = 0; c < 4; c++)
    begin
      xfer({c[1:0], 6'h21}, 8, 1'b1, 8'h00);
      g = 4'hF >> (3 - c);
      snap({2'b10, ~g, g});
    end
    xfer(8'(rnd()) & 8'hDE, 8, 1'b1, 8'h00);
    xfer(8'h20, 7, 1'b0, 8'h00);
    snap(10'h20F);
    for (int c = 0; c < 4; c++) xfer({c[1:0], 6'h20}, 8, 1'b1, 8'h00);
    $display("control test done");
    repeat (3)
    begin
      g = 4'(rnd());
      din = g;
      wait_clk(5);
      snap({2'b10, ~g, g});
      en = 1'b0;
      wait_clk(5);
      snap(10'h2F0);
      en = 1'b1;
    end
    $display("pin test done");
    din = 4'h1;
    drn = 4'h2;
    xfer(8'h61, 8, 1'b1, 8'h00);
    snap(10'h2C3);
    wait_clk(TON00_CYC + TFF_CYC + 10);
    snap(10'h0E1);
    rd(8'h41);
    drn = 4'h0;
    xfer(8'h68, 8, 1'b1, 8'h41);
    snap(10'h2E1);
    rd(8'h00);
    $display("ground short test done");
    din = 4'h8;
    src = 4'h8;
    olt = 4'h8;
    wait_clk(50);
    snap(10'h278);
    din = 4'h0;
    wait_clk(TURN_OFF_BLANK_TIME_CYC - 20);
    snap(10'h2F0);
    wait_clk(TFF_CYC + 50);
    snap(10'h070);
    rd(8'hC6);
    xfer(8'hF0, 8, 1'b1, 8'hC6);
    snap(10'h2F0);
    rd(8'h00);
    src = 4'h0;
    olt = 4'h0;
    xfer(8'hE8, 8, 1'b1, 8'h00);
    rd(8'h00);
    $display("off-state test done");
    din = 4'h1;
    therm = 1'b1;
    wait_clk(10);
    snap(10'h0E1);
    rd(8'h08);
    therm = 1'b0;
    rd(8'h00);
    uv = 1'b1;
    wait_clk(10);
    rd(8'h10);
    uv = 1'b0;
    rd(8'h00);
    din = 4'h0;
    $display("system fault test done");
    xfer(8'h61, 8, 1'b1, 8'h00);
    snap(10'h2D2);
    mrst_n = 1'b0;
    wait_clk(5);
    mrst_n = 1'b1;
    wait_clk(10);
    snap(10'h2F0);
    mrst_n = 1'b0;
    wait_clk(SLEEP_ENTRY_TIME_CYC + 20);
    snap(10'h300);
    mrst_n = 1'b1;
    wait_clk(20);
    snap(10'h2F0);
    $display("reset and sleep test done");
    print_verdict();
  end
endmodule : tb
`default_nettype wire
